// >>> rtl/rsso_pkg.sv
// Package for the rotate, subtract, xor and sleep execution slice.
// Assumes a byte-wide accumulator core with a 7-bit file address.
package rsso_pkg;
	localparam int unsigned DATA_W     = 8;
	localparam int unsigned ADDR_W     = 7;
	localparam int unsigned NIB_W      = 4;
	localparam logic [7:0]  ACC_RST    = 8'h00;
	localparam logic [7:0]  WDT_CLEAR  = 8'h00;
	localparam logic        DEST_ACC   = 1'h0;
	localparam logic        DEST_FILE  = 1'h1;
	localparam logic        FLAG_RST   = 1'h0;
	localparam logic        TO_RST     = 1'h1;
	localparam logic        PD_RST     = 1'h1;

	typedef enum logic [2:0] {
		RSSO_OP_NONE = 3'h0,
		RSSO_OP_RLC  = 3'h1,
		RSSO_OP_RRC  = 3'h2,
		RSSO_OP_SUBL = 3'h3,
		RSSO_OP_XORL = 3'h4,
		RSSO_OP_SLP  = 3'h5
	} rsso_op_t;

	typedef enum logic [0:0] {
		RSSO_RUN   = 1'h0,
		RSSO_SLEEP = 1'h1
	} rsso_pwr_t;
endpackage

// >>> rtl/rsso_alu.sv
// Combinational arithmetic for the rotate, subtract and xor operations.
// Assumes operands come from registers on the same clock.
`timescale 1ns/10ps
module rsso_alu
(
	input  wire rsso_pkg::rsso_op_t op,      // Operation select
	input  wire logic [7:0]         acc,     // Accumulator
	input  wire logic [7:0]         fdat,    // File register value
	input  wire logic [7:0]         lit,     // Literal
	input  wire logic               cin,     // Old carry
	output logic [7:0]              res,     // Result
	output logic                    cout,    // New carry
	output logic                    dcout,   // New digit carry
	output logic                    zout     // Result is zero
);
	logic [8:0] diff;
	logic [4:0] ndiff;

	always_comb
	begin
		diff  = {1'b0, lit} + {1'b0, ~acc} + 9'h001;
		ndiff = {1'b0, lit[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
		res   = 8'h00;
		cout  = cin;
		dcout = 1'b0;
		unique case (op)
			rsso_pkg::RSSO_OP_RLC:
			begin
				res  = {fdat[6:0], cin};
				cout = fdat[7];
			end
			rsso_pkg::RSSO_OP_RRC:
			begin
				res  = {cin, fdat[7:1]};
				cout = fdat[0];
			end
			rsso_pkg::RSSO_OP_SUBL:
			begin
				// No borrow out means acc <= lit
				res   = diff[7:0];
				cout  = diff[8];
				dcout = ndiff[4];
			end
			rsso_pkg::RSSO_OP_XORL:
			begin
				res = acc ^ lit;
			end
			default:
			begin
				res = 8'h00;
			end
		endcase
		zout = (res == 8'h00);
	end
endmodule

// >>> rtl/rsso_core.sv
// Execution slice: rotates through carry, literal subtract and xor, sleep entry.
// Assumes the decoder issues one op per cycle with a one-cycle valid pulse
// and supplies the addressed file register value alongside it.
`timescale 1ns/10ps
module rsso_core
(
	input  wire logic               clk,          // 125 MHz instruction clock
	input  wire logic               rst,          // Synchronous reset, active high
	input  wire logic               op_valid,     // One-cycle instruction strobe
	input  wire rsso_pkg::rsso_op_t op,           // Operation
	input  wire logic [6:0]         file_addr,    // File register address
	input  wire logic               dest,         // Destination select
	input  wire logic [7:0]         file_rdata,   // Addressed file register value
	input  wire logic [7:0]         literal,      // Eight-bit literal
	input  wire logic               wake,         // Wake-up event, same clock
	output logic [7:0]              acc,          // Accumulator
	output logic                    carry,        // Carry flag
	output logic                    digit_carry,  // Digit carry flag
	output logic                    zero,         // Zero flag
	output logic                    timeout_flag, // Timeout status flag
	output logic                    powerdown_flag, // Power-down status flag
	output logic                    file_we,      // File write pulse
	output logic [6:0]              file_waddr,   // File write address
	output logic [7:0]              file_wdata,   // File write data
	output logic                    wdt_clr,      // Watchdog and prescaler clear pulse
	output logic                    osc_run,      // Oscillator enable, low in sleep
	output logic                    sleeping      // Core is in sleep
);

	////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [7:0]          acc;
		logic                c;
		logic                dc;
		logic                z;
		logic                to;
		logic                pd;
		logic                we;
		logic [6:0]          waddr;
		logic [7:0]          wdata;
		logic                wclr;
		logic                osc;
		rsso_pkg::rsso_pwr_t pwr;
	} rsso_state_t;

	rsso_state_t s_q;
	rsso_state_t s_d;
	logic [7:0]  alu_res;
	logic        alu_c;
	logic        alu_dc;
	logic        alu_z;

	rsso_alu u_alu
	(
		.op    (op),
		.acc   (s_q.acc),
		.fdat  (file_rdata),
		.lit   (literal),
		.cin   (s_q.c),
		.res   (alu_res),
		.cout  (alu_c),
		.dcout (alu_dc),
		.zout  (alu_z)
	);

	////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		s_d      = s_q;
		s_d.we   = 1'b0;
		s_d.wclr = 1'b0;
		unique case (s_q.pwr)
			rsso_pkg::RSSO_RUN:
			begin
				// Ops are ignored outside run, so a sleeping core executes nothing
				if (op_valid)
				begin
					unique case (op)
						rsso_pkg::RSSO_OP_RLC, rsso_pkg::RSSO_OP_RRC:
						begin
							s_d.c = alu_c;
							if (dest == rsso_pkg::DEST_FILE)
							begin
								s_d.we    = 1'b1;
								s_d.waddr = file_addr;
								s_d.wdata = alu_res;
							end
							else
							begin
								s_d.acc = alu_res;
							end
						end
						rsso_pkg::RSSO_OP_SUBL:
						begin
							s_d.acc = alu_res;
							s_d.c   = alu_c;
							s_d.dc  = alu_dc;
							s_d.z   = alu_z;
						end
						rsso_pkg::RSSO_OP_XORL:
						begin
							s_d.acc = alu_res;
							s_d.z   = alu_z;
						end
						rsso_pkg::RSSO_OP_SLP:
						begin
							s_d.wclr = 1'b1;
							s_d.to   = 1'b1;
							s_d.pd   = 1'b0;
							s_d.osc  = 1'b0;
							s_d.pwr  = rsso_pkg::RSSO_SLEEP;
						end
						default:
						begin
						end
					endcase
				end
			end
			rsso_pkg::RSSO_SLEEP:
			begin
				// Wake handling proper lives elsewhere; only restart the clock and return to run here
				if (wake)
				begin
					s_d.osc = 1'b1;
					s_d.pwr = rsso_pkg::RSSO_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s_q       <= '0;
			s_q.acc   <= rsso_pkg::ACC_RST;
			s_q.c     <= rsso_pkg::FLAG_RST;
			s_q.dc    <= rsso_pkg::FLAG_RST;
			s_q.z     <= rsso_pkg::FLAG_RST;
			s_q.to    <= rsso_pkg::TO_RST;
			s_q.pd    <= rsso_pkg::PD_RST;
			s_q.osc   <= 1'b1;
			s_q.pwr   <= rsso_pkg::RSSO_RUN;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	assign acc            = s_q.acc;
	assign carry          = s_q.c;
	assign digit_carry    = s_q.dc;
	assign zero           = s_q.z;
	assign timeout_flag   = s_q.to;
	assign powerdown_flag = s_q.pd;
	assign file_we        = s_q.we;
	assign file_waddr     = s_q.waddr;
	assign file_wdata     = s_q.wdata;
	assign wdt_clr        = s_q.wclr;
	assign osc_run        = s_q.osc;
	assign sleeping       = (s_q.pwr == rsso_pkg::RSSO_SLEEP);
endmodule

// >>> sim/rsso_monitor.sv
// Port checker for rsso_core, bound from the bench top.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module rsso_monitor
(
	input wire logic               clk, rst, op_valid, dest, carry, zero, // Clock, strobes
	input wire rsso_pkg::rsso_op_t op,                                    // Operation
	input wire logic [7:0]         file_rdata, literal, acc, file_wdata,  // Data
	input wire logic               file_we, wdt_clr, osc_run, sleeping    // Outputs
);
	logic go;
	assign go = op_valid && !sleeping;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	rlc_result_a: assert property (go && op == 3'h1 && !dest |=> !file_we &&
		acc == {$past(file_rdata[6:0]), $past(carry)} && carry == $past(file_rdata[7]))
		else $error("rotate left result wrong");
	rot_dest_a: assert property (go && (op == 3'h1 || op == 3'h2) && dest |=>
		file_we && $stable(acc)) else $error("rotate to file touched acc");
	rrc_result_a: assert property (go && op == 3'h2 && dest |=>
		file_wdata == {$past(carry), $past(file_rdata[7:1])} && carry == $past(file_rdata[0]))
		else $error("rotate right result wrong");
	wdt_pulse_a: assert property (go && op == 3'h5 |=> wdt_clr ##1 !wdt_clr)
		else $error("watchdog clear not one pulse");
	slp_entry_a: assert property (go && op == 3'h5 |=> !osc_run && sleeping)
		else $error("sleep not entered");
	slp_hold_a: assert property (sleeping |=> $stable(acc) && !file_we)
		else $error("instruction ran in sleep");
	sub_result_a: assert property (go && op == 3'h3 |=> acc == $past(literal) - $past(acc)
		&& carry == ($past(acc) <= $past(literal))) else $error("subtract wrong");
	xor_result_a: assert property (go && op == 3'h4 |=>
		acc == ($past(acc) ^ $past(literal))) else $error("xor wrong");
	zero_flag_a: assert property (go && (op == 3'h3 || op == 3'h4) |=>
		zero == (acc == 8'h00)) else $error("zero flag wrong");
	cover property (go && op == 3'h5);
	cover property (go && op == 3'h3 && acc > literal);
	cover property (go && op == 3'h2 && dest);
endmodule

// >>> sim/tb_rsso_core.sv
// Bench for rsso_core: directed and random instructions, sleep and wake.
// Assumes rsso_monitor is compiled first; the bench plays decoder and file.
`timescale 1ns/10ps
module tb_rsso_core;
	logic               clk = 1'h0;
	logic               rst = 1'h1;
	logic               op_valid = 1'h0;
	logic               dest = 1'h0;
	logic               wake = 1'h0;
	rsso_pkg::rsso_op_t op = rsso_pkg::RSSO_OP_NONE;
	logic [6:0]         file_addr = 7'h00;
	logic [7:0]         file_rdata = 8'h00;
	logic [7:0]         literal = 8'h00;
	logic [7:0]         acc, file_wdata, ma, mwd;
	logic [6:0]         file_waddr, mwa;
	logic               carry, digit_carry, zero, timeout_flag, powerdown_flag;
	logic               file_we, wdt_clr, osc_run, sleeping, t;
	logic               mc, mdc, mz, mto, mpd, mosc;
	logic [31:0]        q[$];
	int                 failures = 0;
	int                 n_checks = 0;
	always #4 clk = ~clk;
	rsso_core u_dut (.clk(clk), .rst(rst), .op_valid(op_valid), .op(op), .file_addr(file_addr),
		.dest(dest), .file_rdata(file_rdata), .literal(literal), .wake(wake), .acc(acc),
		.carry(carry), .digit_carry(digit_carry), .zero(zero), .timeout_flag(timeout_flag),
		.powerdown_flag(powerdown_flag), .file_we(file_we), .file_waddr(file_waddr),
		.file_wdata(file_wdata), .wdt_clr(wdt_clr), .osc_run(osc_run), .sleeping(sleeping));
	function logic [31:0] got();
		return {acc, carry, digit_carry, zero, file_we, file_waddr, file_wdata, timeout_flag,
			powerdown_flag, osc_run, wdt_clr, sleeping};
	endfunction
	function logic [31:0] mdl(input logic we, w, s);
		return {ma, mc, mdc, mz, we, mwa, mwd, mto, mpd, mosc, w, s};
	endfunction
	task automatic chk(input logic [31:0] e, g);
		n_checks++;
		if (e !== g)
		begin
			failures++;
			$display("[ERR] %0t exp %h got %h", $time, e, g);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic issue(input logic [2:0] o, input logic d, input logic [7:0] fd, k,
		input logic [6:0] a);
		logic [7:0] r;
		logic       we;
		logic       slp;
		we = 1'h0;
		slp = o == 3'h5;
		r = (o == 3'h1) ? {fd[6:0], mc} : {mc, fd[7:1]};
		if (o == 3'h1 || o == 3'h2)
		begin
			mc = (o == 3'h1) ? fd[7] : fd[0];
			if (d)
				{we, mwa, mwd} = {1'h1, a, r};
			else
				ma = r;
		end
		if (o == 3'h3)
		begin
			mc = ma <= k;
			mdc = ma[3:0] <= k[3:0];
		end
		ma = (o == 3'h3) ? k - ma : (o == 3'h4) ? ma ^ k : ma;
		if (o == 3'h3 || o == 3'h4)
			mz = ma == 8'h00;
		if (slp)
			{mto, mpd, mosc} = 3'h4;
		q.push_back(mdl(we, slp, slp));
		{op_valid, dest, file_rdata, literal, file_addr} = {1'h1, d, fd, k, a};
		op = rsso_pkg::rsso_op_t'(o);
		@(posedge clk);
		#1;
	endtask
	always @(posedge clk)
	begin
		t = op_valid && !sleeping && !rst;
		#1;
		// Result of an op taken at this edge is settled one step later
		if (t)
			chk(q.pop_front(), got());
	end
	initial
	begin
		#20000;
		failures++;
		give_verdict();
	end
	initial
	begin
		logic [31:0] r;
		void'($urandom(23));
		{ma, mwa, mwd, mc, mdc, mz, mto, mpd, mosc} = 29'h7;
		repeat (8) @(posedge clk);
		#1;
		rst = 1'h0;
		chk(mdl(1'h0, 1'h0, 1'h0), got());
		issue(3'h1, 1'h0, 8'he6, 8'h00, 7'h00);
		issue(3'h2, 1'h1, 8'h01, 8'h00, 7'h05);
		issue(3'h3, 1'h0, 8'h00, 8'hcc, 7'h00);
		issue(3'h4, 1'h0, 8'h00, 8'h18, 7'h00);
		issue(3'h3, 1'h0, 8'h00, 8'h17, 7'h00);
		$display("directed done");
		issue(3'h5, 1'h0, 8'h00, 8'h00, 7'h00);
		op = rsso_pkg::RSSO_OP_XORL;
		literal = 8'hff;
		repeat (3) @(posedge clk);
		#1;
		{op_valid, wake, mosc} = 3'h3;
		@(posedge clk);
		#1;
		wake = 1'h0;
		issue(3'h4, 1'h0, 8'h00, 8'h00, 7'h00);
		$display("sleep done");
		repeat (300)
		begin
			r = $urandom;
			issue((r[26:24] == 3'h5) ? 3'h0 : r[26:24], r[0], r[8:1], r[16:9], r[23:17]);
		end
		op_valid = 1'h0;
		repeat (2) @(posedge clk);
		$display("random done");
		give_verdict();
	end
endmodule
bind rsso_core rsso_monitor u_mon (.clk(clk), .rst(rst), .op_valid(op_valid), .dest(dest),
	.carry(carry), .zero(zero), .op(op), .file_rdata(file_rdata), .literal(literal), .acc(acc),
	.file_wdata(file_wdata), .file_we(file_we), .wdt_clr(wdt_clr), .osc_run(osc_run),
	.sleeping(sleeping));
